// ===== rtl/epi_pkg.sv
/*
  epi_pkg: constants for the external priority interrupt level block.
  assumes a single 250 MHz interrupt logic clock.
*/
package epi_pkg;
  // ==========================================================
  // sizes
  localparam int unsigned LEVEL_CNT   = 16;
  localparam int unsigned CHASSIS_MAX = 14;
  localparam int unsigned CHASSIS_W   = 4;
  // ==========================================================
  // reset values
  localparam logic [15:0] ARM_RST     = 16'h0000;
  localparam logic [15:0] ACK_RST     = 16'h0000;
  localparam logic [15:0] SYNC_RST    = 16'h0000;
  localparam logic [15:0] PEND_RST    = 16'h0000;
  localparam logic        INIT_RST    = 1'b1;
  localparam logic        GV_RST      = 1'b0;
  localparam logic [3:0]  GRANT_RST   = 4'h0;
  // ==========================================================
  // level state
  typedef enum logic [1:0] {
    EPI_IDLE  = 2'b00,
    EPI_ARMED = 2'b01,
    EPI_BUSY  = 2'b10
  } epi_lvl_t;
endpackage

// ===== rtl/epi_levels.sv
/*
  epi_levels: one chassis of sixteen prioritised interrupt levels with acks.
  assumes requests come asynchronous from user logic; the host core arms
  levels, takes the granted level and reports routine completion.
*/
`timescale 1ns/10ps
// Function
// - sixteen levels, each request and ack
// - level zero highest, fifteen lowest priority
// - ack n pairs with request n
// - latch request only on armed level
// - ack usable or ignorable by user
// - ack rises as soon as accepted
// - ack holds until routine completes
// - busy level is not armed, ignores requests
// - too-fast requests go unacknowledged
// - long request may be re-accepted
// - general init output follows processor init
// - chassis priority follows cable position
module epi_levels
  import epi_pkg::*;
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_ce,
  input  wire logic                 i_proc_init,
  input  wire logic [CHASSIS_W-1:0] i_chassis_pos,
  input  wire logic [15:0]          i_level_request,
  input  wire logic [15:0]          i_arm_set,
  input  wire logic [15:0]          i_disarm,
  input  wire logic                 i_grant_take,
  input  wire logic [15:0]          i_service_done,
  input  wire logic                 i_upstream_active,
  output logic      [15:0]          o_level_ack,
  output logic      [15:0]          o_armed,
  output logic                      o_grant_valid,
  output logic      [3:0]           o_grant_level,
  output logic      [CHASSIS_W-1:0] o_grant_chassis,
  output logic                      o_chain_active,
  output logic                      o_general_init_out
);
  // ==========================================================
  // request synchroniser
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;
  logic [15:0] accept;
  logic [15:0] pend_q;
  logic [15:0] take;
  logic        init_q;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else if (i_ce) begin
      sync1_q <= i_level_request;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // per level arm, pending and ack
  logic [15:0] arm_q;
  logic [15:0] ack_q;
  epi_lvl_t    lvl_st [LEVEL_CNT];
  genvar g;
  generate
    for (g = 0; g < LEVEL_CNT; g++) begin : g_lvl
      // level-sensitive accept; a held request is re-accepted once the host re-arms the level
      assign accept[g] = sync2_q[g] & arm_q[g];
      always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          arm_q[g]  <= ARM_RST[g];
          ack_q[g]  <= ACK_RST[g];
          pend_q[g] <= PEND_RST[g];
        end else if (i_ce) begin
          if (init_q) begin
            arm_q[g]  <= 1'b0;
            ack_q[g]  <= 1'b0;
            pend_q[g] <= 1'b0;
          end else if (accept[g]) begin
            arm_q[g]  <= 1'b0;
            ack_q[g]  <= 1'b1;
            pend_q[g] <= 1'b1;
          end else begin
            if (take[g])
              pend_q[g] <= 1'b0;
            if (i_service_done[g] & ~pend_q[g])
              ack_q[g] <= 1'b0;
            if (i_disarm[g])
              arm_q[g] <= 1'b0;
            else if (i_arm_set[g] & ~ack_q[g])
              arm_q[g] <= 1'b1;
          end
        end
      end
      // level state view for the checks
      always_comb begin
        case ({ack_q[g], arm_q[g]})
          2'h0:    lvl_st[g] = EPI_IDLE;
          2'h1:    lvl_st[g] = EPI_ARMED;
          2'h2:    lvl_st[g] = EPI_BUSY;
          default: lvl_st[g] = EPI_BUSY;
        endcase
      end
    end
  endgenerate

  // ==========================================================
  // priority encoder, level zero wins
  logic [3:0] win;
  logic       any;
  always_comb begin
    win = 4'hf;
    any = 1'b0;
    for (int i = LEVEL_CNT - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        win = 4'(i);
        any = 1'b1;
      end
    end
  end
  assign take = (i_grant_take & o_grant_valid) ? (16'h0001 << o_grant_level) : 16'h0000;

  // ==========================================================
  // grant outputs; upstream chassis in cable order blocks us
  logic       gv_q;
  logic [3:0] gl_q;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gv_q <= GV_RST;
      gl_q <= GRANT_RST;
    end else if (i_ce) begin
      gv_q <= any & ~i_upstream_active & ~init_q & ~(i_grant_take & gv_q);
      gl_q <= win;
    end
  end
  assign o_grant_valid   = gv_q;
  assign o_grant_level   = gl_q;
  assign o_grant_chassis = i_chassis_pos;
  assign o_chain_active  = any | i_upstream_active;

  // ==========================================================
  // general init output
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n)
      init_q <= INIT_RST;
    else if (i_ce)
      init_q <= i_proc_init;
  end
  assign o_general_init_out = init_q;
  assign o_level_ack        = ack_q;
  assign o_armed            = arm_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  ack_rise_a: assert property (i_ce && !init_q && accept[0] |=> o_level_ack[0])
    else $error("ack not raised after accept");
  busy_unarm_a: assert property (o_level_ack[3] |-> !o_armed[3])
    else $error("busy level still armed");
  unarmed_ign_a: assert property (i_ce && !arm_q[5] && !ack_q[5] |=> !o_level_ack[5])
    else $error("unarmed level acked");
  ack_hold_a: assert property (o_level_ack[2] && !i_service_done[2] && !init_q && i_ce
                                |=> o_level_ack[2])
    else $error("ack dropped early");
  ack_drop_a: assert property (i_ce && o_level_ack[1] && !pend_q[1] && i_service_done[1]
                                && !accept[1] |=> !o_level_ack[1])
    else $error("ack not dropped on done");
  prio_zero_a: assert property (pend_q[0] |-> win == 4'h0)
    else $error("level zero not winning");
  sync_path_a: assert property (i_ce && sync2_q == 16'h0000 |-> accept == 16'h0000)
    else $error("accept without synced request");
  init_out_a: assert property (i_ce && i_proc_init |=> o_general_init_out)
    else $error("init output not following");
  init_lo_a: assert property (i_ce && !i_proc_init |=> !o_general_init_out)
    else $error("init output stuck high");
  init_grant_a: assert property (i_ce && o_general_init_out |=> !o_grant_valid)
    else $error("grant during init");
  init_clr_a: assert property (o_general_init_out && i_ce |=> o_level_ack == 16'h0000)
    else $error("init did not clear acks");
  chain_blk_a: assert property (i_ce && i_upstream_active |=> !o_grant_valid)
    else $error("grant while upstream active");
  chain_up_a: assert property (i_upstream_active |-> o_chain_active)
    else $error("chain not active for upstream");
  ce_freeze_a: assert property (!i_ce |=> $stable(o_level_ack) && $stable(o_armed)
                                 && $stable(o_grant_valid) && $stable(o_general_init_out))
    else $error("state moved while clock enable low");
  grant_pend_a: assert property (o_grant_valid |-> pend_q[o_grant_level])
    else $error("grant without pending level");
  take_drop_a: assert property (i_ce && i_grant_take && o_grant_valid |=> !o_grant_valid)
    else $error("grant not dropped on take");
  grant_hold_a: assert property (i_ce && o_grant_valid && !i_grant_take && !init_q
                                  && !i_upstream_active |=> o_grant_valid)
    else $error("grant dropped without take");
  busy_st_a: assert property (i_ce && !init_q && lvl_st[0] == EPI_BUSY
                               && !i_service_done[0] |=> lvl_st[0] == EPI_BUSY)
    else $error("busy level left busy early");
  pend_ack_a: assert property (pend_q[0] |-> o_level_ack[0])
    else $error("pending level without ack");
  arm_busy_a: assert property (i_ce && o_level_ack[0] && i_arm_set[0] |=> !o_armed[0])
    else $error("busy level armed");
  disarm_win_a: assert property (i_ce && i_disarm[1] |=> !o_armed[1])
    else $error("disarm lost to arm");
  arm_set_a: assert property (i_ce && !init_q && !accept[0] && i_arm_set[0]
                               && !i_disarm[0] && !o_level_ack[0] |=> o_armed[0])
    else $error("arm not taken");
  sync_delay_a: assert property (i_ce && sync1_q[0] && !sync2_q[0] |=> sync2_q[0])
    else $error("second sync stage missed");

  // ==========================================================
  // covers
  accept_c: cover property (accept[0] ##1 o_level_ack[0]);
  done_c:   cover property (o_level_ack[4] ##1 !o_level_ack[4]);
  prio_c:   cover property (pend_q[0] && pend_q[15]);
  chain_c:  cover property (i_upstream_active && pend_q != 16'h0000);
  rearm_c:  cover property (lvl_st[0] == EPI_BUSY ##1 lvl_st[0] == EPI_IDLE
                            ##1 lvl_st[0] == EPI_ARMED);
endmodule

// ===== bench/epi_user.sv
/*
  epi_user: user equipment model raising level service requests.
  assumes the bench sets i_want just after a rising clock edge.
*/
`timescale 1ns/10ps
module epi_user (
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_want,
  input  wire logic [15:0] i_level_ack,
  output logic      [15:0] o_level_request
);
  // ==========================================================
  // request drive
  logic [15:0] req_q = 16'h0000;
  // held while wanted, dropped and kept low while ack high
  always @(posedge i_mclk) req_q <= #1 i_want & ~i_level_ack;
  assign o_level_request = req_q;
endmodule

// ===== bench/tb_external_priority_interrupt_if.sv
/*
  tb_external_priority_interrupt_if: self-checking bench for epi_levels.
  assumes epi_user drives requests; bench plays the host core.
*/
`timescale 1ns/10ps
module tb_external_priority_interrupt_if;
  import epi_pkg::*;
  // ==========================================================
  // signals
  logic        i_mclk = 0, i_arst_n = 0, i_ce = 1, i_proc_init = 0, i_grant_take = 0;
  logic [3:0]  pos = 4'h5, gl, gc;
  logic [15:0] want = 0, i_arm_set = 0, i_service_done = 0, dis = 0, req, ack, armed, m;
  logic        gv, init_o, chain, up = 0;
  int          err_count = 0, compares = 0, q[$];
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s exp %h got %h", n, e, g); end end
  always #2 i_mclk = ~i_mclk;
  epi_user epi_user_inst (.i_mclk(i_mclk), .i_want(want), .i_level_ack(ack),
    .o_level_request(req));
  epi_levels epi_levels_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_proc_init(i_proc_init), .i_chassis_pos(pos), .i_level_request(req),
    .i_arm_set(i_arm_set), .i_disarm(dis), .i_grant_take(i_grant_take),
    .i_service_done(i_service_done), .i_upstream_active(up), .o_level_ack(ack),
    .o_armed(armed), .o_grant_valid(gv), .o_grant_level(gl), .o_grant_chassis(gc),
    .o_chain_active(chain), .o_general_init_out(init_o));
  // ==========================================================
  // tasks
  task automatic step(int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic print_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    print_verdict;
  end
  // ==========================================================
  // tests
  initial begin
    void'($urandom(32'h3d62));
    step(5);
    `CHK("init_rst", 1'b1, init_o)
    i_arst_n = 1;
    step(2);
    `CHK("init_lo", 1'b0, init_o)
    i_proc_init = 1;
    step(2);
    `CHK("init_hi", 1'b1, init_o)
    i_proc_init = 0;
    want = 16'h0001;
    step(6);
    want = 0;
    step(3);
    `CHK("unarmed", 16'h0000, ack)
    repeat (4) begin
      pos = 4'($urandom % CHASSIS_MAX);
      m = 16'($urandom) | 16'h0001;
      i_arm_set = m;
      step(1);
      i_arm_set = 0;
      step(1);
      `CHK("armed", m, armed)
      want = 16'hffff;
      step(5);
      want = 0;
      `CHK("ack", m, ack)
      `CHK("busy", 16'h0000, armed)
      q = {};
      for (int i = 0; i < 16; i++) if (m[i]) q.push_back(i);
      foreach (q[k]) begin
        step(2);
        `CHK("gv", 1'b1, gv)
        `CHK("level", 4'(q[k]), gl)
        `CHK("chassis", pos, gc)
        `CHK("chain", 1'b1, chain)
        `CHK("ackheld", 1'b1, ack[q[k]])
        i_grant_take = 1;
        step(1);
        i_grant_take = 0;
        i_service_done = 16'h1 << q[k];
        step(1);
        i_service_done = 0;
        step(1);
        `CHK("ackdrop", 1'b0, ack[q[k]])
      end
      want = m;
      step(6);
      want = 0;
      step(2);
      `CHK("refused", 16'h0000, ack)
      `CHK("gv0", 1'b0, gv)
      `CHK("chain0", 1'b0, chain)
    end
    up = 1;
    i_arm_set = 16'h0003;
    dis = 16'h0002;
    step(1);
    i_arm_set = 0;
    dis = 0;
    `CHK("disarm", 16'h0001, armed)
    want = 16'h0001;
    step(5);
    `CHK("ack_up", 16'h0001, ack)
    `CHK("chain_up", 1'b1, chain)
    `CHK("gv_up", 1'b0, gv)
    up = 0;
    i_arm_set = 16'h0001;
    step(1);
    i_arm_set = 0;
    `CHK("busy_arm", 16'h0000, armed)
    `CHK("gv_dn", 1'b1, gv)
    `CHK("lvl0", 4'h0, gl)
    i_grant_take = 1;
    step(1);
    i_grant_take = 0;
    i_service_done = 16'h0001;
    step(1);
    i_service_done = 0;
    `CHK("ack_dn", 16'h0000, ack)
    i_arm_set = 16'h0001;
    step(1);
    i_arm_set = 0;
    step(3);
    `CHK("reaccept", 16'h0001, ack)
    want = 0;
    step(1);
    i_ce = 0;
    i_grant_take = 1;
    step(3);
    `CHK("ce_gv", 1'b1, gv)
    `CHK("ce_ack", 16'h0001, ack)
    i_grant_take = 0;
    i_ce = 1;
    i_arst_n = 0;
    step(1);
    `CHK("rst_ack", 16'h0000, ack)
    `CHK("rst_gv", 1'b0, gv)
    `CHK("rst_init", 1'b1, init_o)
    i_arst_n = 1;
    step(2);
    `CHK("rst_rel", 1'b0, init_o)
    `CHK("rst_arm", 16'h0000, armed)
    print_verdict;
  end
endmodule
